// File: verilog/nv_access_pkg.sv
// Package with constants and types for the nonvolatile self-access controller.
package nv_access_pkg;

    // ------------------------------------------------------------------
    // Register fields and reset values
    // ------------------------------------------------------------------
    localparam int          CTRL_READ_BIT      = 0;
    localparam int          CTRL_WRITE_BIT     = 1;
    localparam int          CTRL_PERMIT_BIT    = 2;
    localparam int          CTRL_ERROR_BIT     = 3;
    localparam int          CTRL_SPACE_BIT     = 7;
    localparam logic [7:0]  UNLOCK_FIRST       = 8'h55;
    localparam logic [7:0]  UNLOCK_SECOND      = 8'haa;
    localparam logic [7:0]  ADDR_RESET         = 8'h00;
    localparam logic [7:0]  DATA_RESET         = 8'h00;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int          PROG_ADDR_BITS     = 13;
    localparam int          PROG_DATA_BITS     = 14;
    localparam int          CLK_PERIOD_NS      = 4;
    localparam int          INSTR_CLOCKS       = 4;
    localparam int          INSTR_NS           = CLK_PERIOD_NS * INSTR_CLOCKS;
    localparam int          DATA_READ_INSTR    = 1;
    localparam int          PROG_READ_INSTR    = 2;
    localparam int          DATA_READ_CYCLES   = DATA_READ_INSTR * INSTR_CLOCKS;
    localparam int          PROG_READ_CYCLES   = PROG_READ_INSTR * INSTR_CLOCKS;
    localparam int          ERASE_TIME_US      = 2000;
    localparam int          PROGRAM_TIME_US    = 2000;
    localparam int          ERASE_CYCLES       = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int          PROGRAM_CYCLES     = PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_READ    = 5'b00010,
        ST_ERASE   = 5'b00100,
        ST_PROGRAM = 5'b01000,
        ST_DONE    = 5'b10000
    } nv_state_t;

    typedef enum logic [2:0] {
        UL_IDLE   = 3'b001,
        UL_FIRST  = 3'b010,
        UL_ARMED  = 3'b100
    } unlock_state_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  data;
    } reg_write_t;

    typedef struct packed {
        logic                      req;
        logic                      space;
        logic                      write;
        logic                      erase;
        logic [15:0]               addr;
        logic [PROG_DATA_BITS-1:0] wdata;
    } mem_req_t;

endpackage : nv_access_pkg

// File: verilog/cycle_timer.sv
// Down counter that times one phase of a memory operation.
`timescale 1ns/100ps
module cycle_timer
    import nv_access_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  expired
);

    logic [WIDTH-1:0] remain_reg;
    logic             run_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remain_reg <= '0;
            run_reg    <= 1'b0;
        end else if (load) begin
            remain_reg <= count;
            run_reg    <= 1'b1;
        end else if (run_reg && remain_reg > WIDTH'(1)) begin
            remain_reg <= remain_reg - WIDTH'(1);
        end else begin
            run_reg    <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= run_reg && !load && remain_reg <= WIDTH'(1);
        end
    end

endmodule : cycle_timer

// File: verilog/nv_self_access.sv
// Controller for core access to data nonvolatile bytes and program words.
//
// Notes on behaviour
// - Every write erases its location first, then programs one byte or word.
// - No bulk erase path exists; only single-location erase then program.
// - Core stalls and program memory is unavailable during a program write.
// - Clock and peripherals run on; interrupts are held pending during program write.
// - After program write, next pipelined instruction runs, then pending interrupt vectors.
// - Small data space: top address bit not cleared; 0x80 passes on and does not wrap to 0x00.
// - Large data space decodes all eight low address bits.
// - Program address is high:low address bytes, all 16 bits passed on.
// - Program data is high:low data registers as one 14-bit value.
// - Program addresses beyond range are not wrapped back to zero.
// - Unlock port has no storage; writes only step the unlock sequence.
// - Space select steers accesses to data space or program space.
// - Read-start launches a read; only hardware clears it at read end.
// - Data read result lands in low data register one instruction later.
// - Program read result lands after the second following instruction.
// - Writes are refused while the program permit bit is clear.
// - Write-start begins a write cycle; hardware clears it at cycle end.
// - Data write erases, programs low data byte while core runs, sets done flag.
// - Program write erases, programs word, sets done flag, resumes core.
// - Master clear or watchdog reset during a write sets the interrupted flag.
// - Those resets leave data, address and space select registers unchanged.
// - A write arms only after 55h then AAh reach the unlock port.
// - Write-start honoured only if permit was set by an earlier write.
// - Software zeros to read-start or write-start are ignored.
// - Data registers hold the read value until another read or firmware write.
`timescale 1ns/100ps
module nv_self_access
    import nv_access_pkg::*;
#(
    parameter int          DATA_ADDR_BITS = 8,
    parameter int          ERASE_COUNT    = ERASE_CYCLES,
    parameter int          PROGRAM_COUNT  = PROGRAM_CYCLES,
    parameter int          TIMER_WIDTH    = 24
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      master_clear_reset,
    input  wire logic                      watchdog_timeout,
    input  wire reg_write_t                data_low_byte_wr,
    input  wire reg_write_t                data_high_bits_wr,
    input  wire reg_write_t                addr_low_byte_wr,
    input  wire reg_write_t                addr_high_byte_wr,
    input  wire reg_write_t                access_control_wr,
    input  wire reg_write_t                unlock_port_wr,
    input  wire logic                      other_access,
    input  wire logic                      done_flag_clear,
    input  wire logic                      error_flag_clear,
    input  wire logic                      irq_event,
    input  wire logic                      pipeline_step,
    input  wire logic [PROG_DATA_BITS-1:0] mem_rdata,
    input  wire logic                      mem_ack,
    output logic [7:0]                     data_low_byte,
    output logic [7:0]                     data_high_bits,
    output logic [7:0]                     addr_low_byte,
    output logic [7:0]                     addr_high_byte,
    output logic [7:0]                     access_control,
    output logic                           cycle_done_flag,
    output mem_req_t                       mem_req,
    output logic                           core_stall,
    output logic                           prog_mem_busy,
    output logic                           irq_pending,
    output logic                           irq_vector_take
);

    // ------------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------------
    logic          space_select_reg;
    logic          program_permit_reg;
    logic          interrupted_cycle_flag_reg;
    logic          write_start_reg;
    logic          read_start_reg;
    nv_state_t     state_reg;
    unlock_state_t unlock_reg;
    logic          soft_reset;
    logic          ctrl_wr;
    logic          start_write;
    logic          start_read;
    logic          busy;
    logic          timer_load;
    logic [TIMER_WIDTH-1:0] timer_count;
    logic          timer_expired;
    logic [3:0]    read_cnt_reg;
    logic          irq_hold_reg;
    logic          resume_reg;

    // Soft resets leave the address, data and space select alone.
    assign soft_reset  = master_clear_reset || watchdog_timeout;
    assign ctrl_wr     = access_control_wr.wr;
    assign busy        = state_reg != ST_IDLE;
    assign start_write = ctrl_wr && access_control_wr.data[CTRL_WRITE_BIT] && program_permit_reg
                         && unlock_reg == UL_ARMED && !busy;
    assign start_read  = ctrl_wr && access_control_wr.data[CTRL_READ_BIT] && !busy
                         && !start_write;

    // ------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------
    // The unlock port is a decoder only; nothing written there is stored.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_reg <= UL_IDLE;
        end else if (soft_reset) begin
            unlock_reg <= UL_IDLE;
        end else if (unlock_port_wr.wr) begin
            unique case (unlock_reg)
                UL_IDLE:  unlock_reg <= (unlock_port_wr.data == UNLOCK_FIRST) ? UL_FIRST : UL_IDLE;
                UL_FIRST: unlock_reg <= (unlock_port_wr.data == UNLOCK_SECOND) ? UL_ARMED
                                       : UL_IDLE;
                UL_ARMED: unlock_reg <= UL_IDLE;
            endcase
        end else if (ctrl_wr || other_access || data_low_byte_wr.wr || data_high_bits_wr.wr
                     || addr_low_byte_wr.wr || addr_high_byte_wr.wr) begin
            unlock_reg <= UL_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            space_select_reg <= 1'b0;
        end else if (ctrl_wr && !busy) begin
            space_select_reg <= access_control_wr.data[CTRL_SPACE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            program_permit_reg <= 1'b0;
        end else if (soft_reset) begin
            program_permit_reg <= 1'b0;
        end else if (ctrl_wr) begin
            program_permit_reg <= access_control_wr.data[CTRL_PERMIT_BIT];
        end
    end

    // Start bits are set-only from software; zeros written are ignored.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_start_reg <= 1'b0;
        end else if (soft_reset) begin
            write_start_reg <= 1'b0;
        end else if (start_write) begin
            write_start_reg <= 1'b1;
        end else if (state_reg == ST_DONE) begin
            write_start_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            read_start_reg <= 1'b0;
        end else if (soft_reset) begin
            read_start_reg <= 1'b0;
        end else if (start_read) begin
            read_start_reg <= 1'b1;
        end else if (state_reg == ST_READ && read_cnt_reg == 4'h1) begin
            read_start_reg <= 1'b0;
        end
    end

    // A reset that cuts a write short is remembered; a new error beats a clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            interrupted_cycle_flag_reg <= 1'b0;
        end else if (soft_reset && (state_reg == ST_ERASE || state_reg == ST_PROGRAM)) begin
            interrupted_cycle_flag_reg <= 1'b1;
        end else if (error_flag_clear) begin
            interrupted_cycle_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_done_flag <= 1'b0;
        end else if (state_reg == ST_DONE) begin
            cycle_done_flag <= 1'b1;
        end else if (done_flag_clear) begin
            cycle_done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else if (soft_reset) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_write) begin
                        state_reg <= ST_ERASE;
                    end else if (start_read) begin
                        state_reg <= ST_READ;
                    end
                end
                ST_READ:    state_reg <= (read_cnt_reg == 4'h1) ? ST_IDLE : ST_READ;
                ST_ERASE:   state_reg <= timer_expired ? ST_PROGRAM : ST_ERASE;
                ST_PROGRAM: state_reg <= timer_expired ? ST_DONE : ST_PROGRAM;
                ST_DONE:    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Read latency counts core clock cycles, four to each instruction cycle.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            read_cnt_reg <= 4'h0;
        end else if (start_read) begin
            read_cnt_reg <= access_control_wr.data[CTRL_SPACE_BIT] ? 4'(PROG_READ_CYCLES)
                            : 4'(DATA_READ_CYCLES);
        end else if (read_cnt_reg != 4'h0) begin
            read_cnt_reg <= read_cnt_reg - 4'h1;
        end
    end

    assign timer_load  = start_write || (state_reg == ST_ERASE && timer_expired);
    assign timer_count = (state_reg == ST_ERASE) ? TIMER_WIDTH'(PROGRAM_COUNT)
                         : TIMER_WIDTH'(ERASE_COUNT);

    cycle_timer #(
        .WIDTH   (TIMER_WIDTH)
    ) u_timer (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .load    (timer_load),
        .count   (timer_count),
        .expired (timer_expired)
    );

    // ------------------------------------------------------------------
    // Memory request
    // ------------------------------------------------------------------
    // Only single-location erase, program and read commands are ever issued.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= '0;
        end else begin
            mem_req.req   <= timer_load || start_read;
            mem_req.write <= timer_load && state_reg == ST_ERASE;
            mem_req.erase <= start_write;
            mem_req.space <= start_read ? access_control_wr.data[CTRL_SPACE_BIT]
                             : space_select_reg;
            // Address passes unwrapped; the memory decides what lies out of range.
            mem_req.addr  <= (start_read ? access_control_wr.data[CTRL_SPACE_BIT]
                              : space_select_reg)
                             ? {addr_high_byte, addr_low_byte}
                             : {8'h00, addr_low_byte};
            mem_req.wdata <= space_select_reg ? {data_high_bits[5:0], data_low_byte}
                             : {6'h00, data_low_byte};
        end
    end

    // ------------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_low_byte  <= ADDR_RESET;
            addr_high_byte <= ADDR_RESET;
        end else begin
            if (addr_low_byte_wr.wr) begin
                addr_low_byte <= addr_low_byte_wr.data;
            end
            if (addr_high_byte_wr.wr) begin
                addr_high_byte <= addr_high_byte_wr.data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_low_byte  <= DATA_RESET;
            data_high_bits <= DATA_RESET;
        end else if (state_reg == ST_READ && mem_ack) begin
            data_low_byte  <= mem_rdata[7:0];
            data_high_bits <= space_select_reg ? {2'b00, mem_rdata[PROG_DATA_BITS-1:8]}
                              : data_high_bits;
        end else begin
            if (data_low_byte_wr.wr) begin
                data_low_byte <= data_low_byte_wr.data;
            end
            if (data_high_bits_wr.wr) begin
                data_high_bits <= {2'b00, data_high_bits_wr.data[5:0]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            access_control <= 8'h00;
        end else begin
            access_control <= {space_select_reg, 3'h0, interrupted_cycle_flag_reg,
                               program_permit_reg, write_start_reg, read_start_reg};
        end
    end

    // ------------------------------------------------------------------
    // Core stall and interrupt holding
    // ------------------------------------------------------------------
    // Stall is held through the done cycle so the core resumes only once done is set.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_stall    <= 1'b0;
            prog_mem_busy <= 1'b0;
        end else begin
            core_stall    <= space_select_reg && (start_write || state_reg == ST_ERASE
                             || state_reg == ST_PROGRAM) && !soft_reset;
            prog_mem_busy <= space_select_reg && (start_write || state_reg == ST_ERASE
                             || state_reg == ST_PROGRAM) && !soft_reset;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_hold_reg <= 1'b0;
        end else if (core_stall && irq_event) begin
            irq_hold_reg <= 1'b1;
        end else if (irq_vector_take || soft_reset) begin
            irq_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resume_reg <= 1'b0;
        end else if (core_stall) begin
            resume_reg <= 1'b0;
        end else if (irq_hold_reg && !resume_reg) begin
            resume_reg <= 1'b1;
        end
    end

    // The queued vector fires only after one pipelined instruction has completed.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending     <= 1'b0;
            irq_vector_take <= 1'b0;
        end else begin
            irq_pending     <= irq_hold_reg && !irq_vector_take;
            irq_vector_take <= resume_reg && irq_hold_reg && pipeline_step
                               && !core_stall && !irq_vector_take;
        end
    end

endmodule : nv_self_access

// File: tb/nv_self_access_assertions.sv
// Port checker for the nonvolatile self-access controller.
`timescale 1ns/100ps
module nv_self_access_assertions
    import nv_access_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       master_clear_reset,
    input wire logic       watchdog_timeout,
    input wire reg_write_t data_high_bits_wr,
    input wire reg_write_t addr_low_byte_wr,
    input wire logic       irq_event,
    input wire logic [7:0] data_high_bits,
    input wire logic [7:0] addr_low_byte,
    input wire logic [7:0] access_control,
    input wire logic       cycle_done_flag,
    input wire mem_req_t   mem_req,
    input wire logic       core_stall,
    input wire logic       prog_mem_busy,
    input wire logic       irq_pending,
    input wire logic       irq_vector_take
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_stall_busy_same: assert property (core_stall == prog_mem_busy)
        else $error("stall and busy differ");
    chk_stall_prog_space: assert property (core_stall |-> access_control[CTRL_SPACE_BIT])
        else $error("stall outside program space");
    // A soft reset aborts the cycle, so the program step may never come.
    chk_erase_then_prog: assert property (disable iff (!rst_n || master_clear_reset || watchdog_timeout)
        mem_req.req && mem_req.erase |-> ##[1:40] mem_req.req && mem_req.write && !mem_req.erase)
        else $error("erase not followed by program");
    chk_start_permit: assert property ($rose(access_control[CTRL_WRITE_BIT])
        |-> $past(access_control[CTRL_PERMIT_BIT]))
        else $error("write started without permit");
    chk_read_clears: assert property ($rose(access_control[CTRL_READ_BIT]) |-> ##[1:12] !access_control[CTRL_READ_BIT])
        else $error("read start not cleared");
    chk_done_ends_write: assert property ($rose(cycle_done_flag) |-> ##[0:2] !access_control[CTRL_WRITE_BIT])
        else $error("write start stands after done");
    chk_data_held: assert property (!$stable(data_high_bits) |-> $past(data_high_bits_wr.wr) || $past(data_high_bits_wr.wr, 2)
        || access_control[CTRL_READ_BIT] || $past(access_control[CTRL_READ_BIT])) else $error("data changed unprompted");
    chk_irq_held: assert property (irq_event && core_stall |-> ##2 irq_pending)
        else $error("event during stall lost");
    chk_vector_free: assert property (irq_vector_take |-> !core_stall)
        else $error("vector taken while stalled");
    chk_error_abort: assert property ((master_clear_reset || watchdog_timeout) && core_stall |-> ##[1:2] access_control[CTRL_ERROR_BIT])
        else $error("aborted write not flagged");
    chk_addr_kept: assert property (master_clear_reset && !addr_low_byte_wr.wr |=> $stable(addr_low_byte))
        else $error("address lost on soft reset");
    cov_prog_stall: cover property ($rose(core_stall));
    cov_done: cover property ($rose(cycle_done_flag));
    cov_vector: cover property (irq_vector_take);
endmodule : nv_self_access_assertions
bind nv_self_access nv_self_access_assertions nv_self_access_assertions_i (.mclk, .rst_n,
    .master_clear_reset, .watchdog_timeout, .data_high_bits_wr, .addr_low_byte_wr, .irq_event,
    .data_high_bits, .addr_low_byte, .access_control, .cycle_done_flag, .mem_req, .core_stall,
    .prog_mem_busy, .irq_pending, .irq_vector_take);

// File: tb/testbench.sv
// Self-checking testbench for the nonvolatile self-access controller.
`timescale 1ns/100ps
module testbench;
    import nv_access_pkg::*;
    logic mclk = 0, rst_n = 0, mcr = 0, wdt = 0, oth = 0, dclr = 0, eclr = 0, irq = 0, step = 0;
    logic [13:0] rdata = 14'h0000;
    reg_write_t  wb [6] = '{default: '0};
    logic [7:0]  dl, dh, al, ah, ac;
    logic        done, stall, busy, pend, vec;
    mem_req_t    mr;
    mem_req_t    reqs[$];
    int          error_cnt = 0, check_count = 0, i;
    initial forever #2 mclk = ~mclk;
    // Short phase counts keep the run brief.
    nv_self_access #(.ERASE_COUNT(8), .PROGRAM_COUNT(8)) nv_self_access_i (.mclk(mclk), .rst_n(rst_n),
        .master_clear_reset(mcr), .watchdog_timeout(wdt), .data_low_byte_wr(wb[0]),
        .data_high_bits_wr(wb[1]), .addr_low_byte_wr(wb[2]), .addr_high_byte_wr(wb[3]),
        .access_control_wr(wb[4]), .unlock_port_wr(wb[5]), .other_access(oth), .done_flag_clear(dclr),
        .error_flag_clear(eclr), .irq_event(irq), .pipeline_step(step), .mem_rdata(rdata),
        .mem_ack(1'b1), .data_low_byte(dl), .data_high_bits(dh), .addr_low_byte(al),
        .addr_high_byte(ah), .access_control(ac), .cycle_done_flag(done), .mem_req(mr),
        .core_stall(stall), .prog_mem_busy(busy), .irq_pending(pend), .irq_vector_take(vec));
    always @(posedge mclk) if (mr.req === 1'b1) reqs.push_back(mr);
    task automatic put(input int k, input logic [7:0] v);
        wb[k] = '{1'b1, v};
        @(negedge mclk);
        wb[k].wr = 1'b0;
    endtask : put
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic unlock_start(input logic [7:0] v);
        wb[5] = '{1'b1, UNLOCK_FIRST};
        @(negedge mclk);
        wb[5].data = UNLOCK_SECOND;
        @(negedge mclk);
        wb[5].wr = 1'b0;
        put(4, v);
    endtask : unlock_start
    task automatic wait_done();
        for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge mclk);
        check(done, 1);
        @(negedge mclk);
    endtask : wait_done
    task automatic test_reads();
        reqs = {};
        rdata = 14'h02a5;
        put(2, 8'h80);
        put(4, 8'h01);
        repeat (12) @(negedge mclk);
        check(dl, 8'ha5);
        check(ac[CTRL_READ_BIT], 0);
        check({reqs[0].space, reqs[0].addr[7:0]}, 9'h080);
        rdata = 14'h3c5a;
        put(3, 8'h2f);
        put(4, 8'h81);
        repeat (12) @(negedge mclk);
        check({dh[5:0], dl}, 14'h3c5a);
        check({reqs[1].space, reqs[1].addr}, 17'h12f80);
        $display("reads done");
    endtask : test_reads
    task automatic test_refused();
        reqs = {};
        put(4, 8'h02);
        unlock_start(8'h06);
        put(5, UNLOCK_FIRST);
        oth = 1;
        @(negedge mclk) oth = 0;
        put(5, UNLOCK_SECOND);
        put(4, 8'h06);
        repeat (4) @(negedge mclk);
        check(reqs.size(), 0);
        check(ac[CTRL_WRITE_BIT], 0);
        $display("refusals done");
    endtask : test_refused
    task automatic test_data_write();
        reqs = {};
        dclr = 1;
        @(negedge mclk) dclr = 0;
        put(0, 8'h3c);
        unlock_start(8'h06);
        wait_done();
        check({reqs[0].erase, reqs[1].write, reqs[1].wdata[7:0]}, 10'h33c);
        check({ac[CTRL_WRITE_BIT], busy}, 0);
        $display("data write done");
    endtask : test_data_write
    task automatic test_prog_write();
        reqs = {};
        put(1, 8'h12);
        put(0, 8'h34);
        put(4, 8'h84);
        dclr = 1;
        @(negedge mclk) dclr = 0;
        unlock_start(8'h86);
        repeat (2) @(negedge mclk);
        check({stall, busy}, 2'b11);
        irq = 1;
        @(negedge mclk) irq = 0;
        @(negedge mclk);
        check(pend, 1);
        wait_done();
        check({stall, reqs[1].space, reqs[1].wdata}, 16'h5234);
        step = 1;
        @(negedge mclk) step = 0;
        for (i = 0; i < 8 && vec !== 1'b1; i++) @(negedge mclk);
        check(vec, 1);
        $display("program write done");
    endtask : test_prog_write
    task automatic test_soft_reset();
        for (int k = 0; k < 2; k++) begin
            unlock_start(8'h86);
            repeat (4) @(negedge mclk);
            mcr = (k == 0);
            wdt = (k == 1);
            @(negedge mclk);
            {mcr, wdt} = 2'b00;
            repeat (2) @(negedge mclk);
            check(ac[CTRL_ERROR_BIT], 1);
            check({ac[CTRL_SPACE_BIT], ah, al}, 17'h12f80);
            check({dh[5:0], dl}, 14'h1234);
            eclr = 1;
            put(4, 8'h84);
            eclr = 0;
        end
        $display("soft resets done");
    endtask : test_soft_reset
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1;
        test_reads();
        test_refused();
        test_data_write();
        test_prog_write();
        test_soft_reset();
        tally_and_finish();
    end
endmodule : testbench
